/* File: hdl/nvac_pkg.sv */
package nvac_pkg;

    // Register locations on the special function register port.
    localparam logic [8:0] ADDR_REG_LOC   = 9'h0_00;
    localparam logic [8:0] DATA_REG_LOC   = 9'h0_01;
    localparam logic [7:0] CTRL_LOW_LOC   = 8'h40;
    localparam logic [7:0] CTRL_SECTOR    = 8'h01;
    localparam logic [8:0] CTRL_REG_LOC   = {CTRL_SECTOR[0], CTRL_LOW_LOC};

    // Control register field positions.
    localparam int         RD_POS         = 0;
    localparam int         READ_ENABLE_BIT_POS       = 1;
    localparam int         WR_POS         = 2;
    localparam int         WRITE_ENABLE_BIT_POS       = 3;

    // Values after reset.
    localparam logic [4:0] ADDR_RESET     = 5'h00;
    localparam logic [7:0] DATA_RESET     = 8'h00;
    localparam logic [3:0] CTRL_RESET     = 4'h0;

    // Array geometry.
    localparam int         ARRAY_DEPTH    = 32;
    localparam int         ADDR_WIDTH     = 5;

    // Timing at a 25 MHz core clock.
    localparam int         CLK_PERIOD_NS  = 40;
    localparam int         READ_TIME_NS   = 80;
    localparam int         READ_CYCLES    =
        (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] READ_CNT_LAST  = 2'(READ_CYCLES - 1);

    // One-hot access sequencer states.
    typedef enum logic [2:0] {
        NVAC_IDLE  = 3'b001,
        NVAC_READ  = 3'b010,
        NVAC_WRITE = 3'b100
    } nvac_state_t;

endpackage : nvac_pkg

/* File: hdl/nvac_write_timer.sv */
`timescale 1ns/100ps
// Free running timer tick, brought over into the core clock domain.
module nvac_write_timer (
    input  wire logic core_clk_in,      // Core clock.
    input  wire logic rst_n_in,         // Asynchronous reset, active low.
    input  wire logic timer_tick_in,    // Asynchronous timer level.
    output logic      tick_pulse_out    // One cycle pulse per rising timer edge.
);

    logic sync1_ff;
    logic sync2_ff;
    logic sync3_ff;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
        end else begin
            sync1_ff <= timer_tick_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // Only settled stages feed the edge detector.
    assign tick_pulse_out = sync2_ff & ~sync3_ff;

endmodule : nvac_write_timer

/* File: hdl/nvac_access_ctrl.sv */
`timescale 1ns/100ps
// What this block does
// - Five-bit address register, upper bits read zero.
// - Eight-bit data register, reset to zero.
// - Control register at 40H of sector one.
// - Address and data registers in sector zero.
// - Write enable clear inhibits array writes.
// - Write strobe starts write, hardware clears it.
// - Write strobe ignored unless enable set before.
// - Read enable clear inhibits array reads.
// - Read strobe starts read, hardware clears it.
// - Read strobe ignored unless enable set before.
// - Fetched byte stays until next operation.
// - Array holds thirty-two bytes.
// - Write duration set by asynchronous timer.
// - Each finished write raises done flag.
module nvac_access_ctrl (
    input  wire logic       core_clk_in,     // 25 MHz core clock.
    input  wire logic       rst_n_in,        // Async reset, active low.
    input  wire logic [8:0] sfr_addr_in,     // Sector bit and location.
    input  wire logic       sfr_wr_in,       // Register write strobe.
    input  wire logic [7:0] sfr_wdata_in,    // Register write data.
    output logic      [7:0] sfr_rdata_out,   // Register read data.
    input  wire logic       timer_tick_in,   // Async write timer level.
    output logic            write_done_flag_out // Write finished pulse.
);

    localparam int ADDR_WIDTH_L = nvac_pkg::ADDR_WIDTH;

    logic [ADDR_WIDTH_L-1:0] nvm_address_reg_ff;
    logic [7:0]              nvm_data_reg_ff;
    logic                    write_enable_bit_ff;
    logic                    write_strobe_ff;
    logic                    read_enable_bit_ff;
    logic                    read_strobe_ff;
    logic [ADDR_WIDTH_L-1:0] op_addr_ff;
    logic [7:0]              op_data_ff;
    logic [1:0]              read_cnt_ff;
    logic                    write_done_flag_ff;
    logic [7:0]              cell_mem [nvac_pkg::ARRAY_DEPTH];
    nvac_pkg::nvac_state_t   state_ff;
    logic                    tick_pulse;
    logic                    wr_addr_sel;
    logic                    wr_data_sel;
    logic                    wr_ctrl_sel;
    logic                    start_read;
    logic                    start_write;
    logic                    read_last;

    nvac_write_timer u_timer (
        .core_clk_in    (core_clk_in),
        .rst_n_in       (rst_n_in),
        .timer_tick_in  (timer_tick_in),
        .tick_pulse_out (tick_pulse)
    );

    assign wr_addr_sel = sfr_wr_in &&
                         sfr_addr_in == nvac_pkg::ADDR_REG_LOC;
    assign wr_data_sel = sfr_wr_in &&
                         sfr_addr_in == nvac_pkg::DATA_REG_LOC;
    assign wr_ctrl_sel = sfr_wr_in &&
                         sfr_addr_in == nvac_pkg::CTRL_REG_LOC;

    // Strobes count only if the enable was already stored beforehand.
    assign start_read  = wr_ctrl_sel && state_ff == nvac_pkg::NVAC_IDLE &&
                         sfr_wdata_in[nvac_pkg::RD_POS] &&
                         read_enable_bit_ff &&
                         !sfr_wdata_in[nvac_pkg::WR_POS];
    assign start_write = wr_ctrl_sel && state_ff == nvac_pkg::NVAC_IDLE &&
                         sfr_wdata_in[nvac_pkg::WR_POS] &&
                         write_enable_bit_ff &&
                         !sfr_wdata_in[nvac_pkg::RD_POS];
    assign read_last   = read_cnt_ff == nvac_pkg::READ_CNT_LAST;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            nvm_address_reg_ff <= nvac_pkg::ADDR_RESET;
        end else if (wr_addr_sel) begin
            nvm_address_reg_ff <= sfr_wdata_in[ADDR_WIDTH_L-1:0];
        end
    end

    // The fetched byte overwrites software data at the end of a read.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            nvm_data_reg_ff <= nvac_pkg::DATA_RESET;
        end else if (state_ff == nvac_pkg::NVAC_READ && read_last) begin
            nvm_data_reg_ff <= cell_mem[op_addr_ff];
        end else if (wr_data_sel) begin
            nvm_data_reg_ff <= sfr_wdata_in;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            write_enable_bit_ff <= nvac_pkg::CTRL_RESET[nvac_pkg::WRITE_ENABLE_BIT_POS];
            read_enable_bit_ff  <= nvac_pkg::CTRL_RESET[nvac_pkg::READ_ENABLE_BIT_POS];
        end else if (wr_ctrl_sel) begin
            write_enable_bit_ff <= sfr_wdata_in[nvac_pkg::WRITE_ENABLE_BIT_POS];
            read_enable_bit_ff  <= sfr_wdata_in[nvac_pkg::READ_ENABLE_BIT_POS];
        end
    end

    // Strobes are busy flags: software may only set them, hardware clears.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            write_strobe_ff <= nvac_pkg::CTRL_RESET[nvac_pkg::WR_POS];
            read_strobe_ff  <= nvac_pkg::CTRL_RESET[nvac_pkg::RD_POS];
        end else begin
            if (start_write) begin
                write_strobe_ff <= 1'b1;
            end else if (state_ff == nvac_pkg::NVAC_WRITE && tick_pulse) begin
                write_strobe_ff <= 1'b0;
            end
            if (start_read) begin
                read_strobe_ff <= 1'b1;
            end else if (state_ff == nvac_pkg::NVAC_READ && read_last) begin
                read_strobe_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff    <= nvac_pkg::NVAC_IDLE;
            op_addr_ff  <= nvac_pkg::ADDR_RESET;
            op_data_ff  <= nvac_pkg::DATA_RESET;
            read_cnt_ff <= 2'h0;
        end else begin
            case (state_ff)
                nvac_pkg::NVAC_IDLE: begin
                    read_cnt_ff <= 2'h0;
                    if (start_write) begin
                        op_addr_ff <= nvm_address_reg_ff;
                        op_data_ff <= nvm_data_reg_ff;
                        state_ff   <= nvac_pkg::NVAC_WRITE;
                    end else if (start_read) begin
                        op_addr_ff <= nvm_address_reg_ff;
                        state_ff   <= nvac_pkg::NVAC_READ;
                    end
                end
                nvac_pkg::NVAC_READ: begin
                    read_cnt_ff <= read_cnt_ff + 2'h1;
                    if (read_last) begin
                        state_ff <= nvac_pkg::NVAC_IDLE;
                    end
                end
                nvac_pkg::NVAC_WRITE: begin
                    // Duration is set by the asynchronous timer only.
                    if (tick_pulse) begin
                        state_ff <= nvac_pkg::NVAC_IDLE;
                    end
                end
                default: begin
                    state_ff <= nvac_pkg::NVAC_IDLE;
                end
            endcase
        end
    end

    // The array has no reset, like a real nonvolatile cell block.
    always_ff @(posedge core_clk_in) begin
        if (state_ff == nvac_pkg::NVAC_WRITE && tick_pulse) begin
            cell_mem[op_addr_ff] <= op_data_ff;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            write_done_flag_ff <= 1'b0;
        end else begin
            write_done_flag_ff <= state_ff == nvac_pkg::NVAC_WRITE &&
                                  tick_pulse;
        end
    end

    assign write_done_flag_out = write_done_flag_ff;

    always_comb begin
        sfr_rdata_out = 8'h00;
        case (sfr_addr_in)
            nvac_pkg::ADDR_REG_LOC: sfr_rdata_out = {3'h0, nvm_address_reg_ff};
            nvac_pkg::DATA_REG_LOC: sfr_rdata_out = nvm_data_reg_ff;
            nvac_pkg::CTRL_REG_LOC: sfr_rdata_out = {4'h0,
                write_enable_bit_ff, write_strobe_ff,
                read_enable_bit_ff, read_strobe_ff};
            default: sfr_rdata_out = 8'h00;
        endcase
    end

    property p_write_needs_enable;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        $rose(write_strobe_ff) |-> $past(write_enable_bit_ff);
    endproperty
    a_write_needs_enable: assert property (p_write_needs_enable)
        else $error("Write strobe set without prior enable.");

    property p_read_needs_enable;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        $rose(read_strobe_ff) |-> $past(read_enable_bit_ff);
    endproperty
    a_read_needs_enable: assert property (p_read_needs_enable)
        else $error("Read strobe set without prior enable.");

    property p_read_ends;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        $rose(read_strobe_ff) |-> read_strobe_ff[*2] ##1 !read_strobe_ff;
    endproperty
    a_read_ends: assert property (p_read_ends)
        else $error("Read strobe did not clear after two cycles.");

    property p_done_at_write_end;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        $fell(write_strobe_ff) |-> write_done_flag_ff;
    endproperty
    a_done_at_write_end: assert property (p_done_at_write_end)
        else $error("Write end without done flag.");

    property p_done_only_after_write;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        write_done_flag_ff |-> $past(state_ff) == nvac_pkg::NVAC_WRITE;
    endproperty
    a_done_only_after_write: assert property (p_done_only_after_write)
        else $error("Done flag outside a write.");

    property p_data_holds;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (state_ff == nvac_pkg::NVAC_IDLE && !wr_data_sel)
            |=> $stable(nvm_data_reg_ff);
    endproperty
    a_data_holds: assert property (p_data_holds)
        else $error("Data register changed without an operation.");

    property p_addr_upper_zero;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        sfr_addr_in == nvac_pkg::ADDR_REG_LOC |-> sfr_rdata_out[7:5] == 3'h0;
    endproperty
    a_addr_upper_zero: assert property (p_addr_upper_zero)
        else $error("Address register upper bits not zero.");

    property p_one_op;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        !(read_strobe_ff && write_strobe_ff);
    endproperty
    a_one_op: assert property (p_one_op)
        else $error("Read and write active together.");

    c_read: cover property (@(posedge core_clk_in) $fell(read_strobe_ff));
    c_write: cover property (@(posedge core_clk_in) write_done_flag_ff);
    c_refused: cover property (@(posedge core_clk_in)
        wr_ctrl_sel && sfr_wdata_in[nvac_pkg::WR_POS] && !start_write);

endmodule : nvac_access_ctrl

/* File: verification/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    localparam logic [8:0] AREG = nvac_pkg::ADDR_REG_LOC;
    localparam logic [8:0] DREG = nvac_pkg::DATA_REG_LOC;
    localparam logic [8:0] CREG = nvac_pkg::CTRL_REG_LOC;

    logic       core_clk_in;
    logic       rst_n_in;
    logic [8:0] sfr_addr_in;
    logic       sfr_wr_in;
    logic [7:0] sfr_wdata_in;
    logic [7:0] sfr_rdata_out;
    logic       timer_tick_in;
    logic       write_done_flag_out;
    int         miscompares;
    int         checks_done;
    int         dones_seen;
    int         dones_exp;
    logic [7:0] mem [32];
    logic [31:0] seed;

    nvac_access_ctrl uut (
        .core_clk_in         (core_clk_in),
        .rst_n_in            (rst_n_in),
        .sfr_addr_in         (sfr_addr_in),
        .sfr_wr_in           (sfr_wr_in),
        .sfr_wdata_in        (sfr_wdata_in),
        .sfr_rdata_out       (sfr_rdata_out),
        .timer_tick_in       (timer_tick_in),
        .write_done_flag_out (write_done_flag_out)
    );

    initial begin
        core_clk_in = 1'b0;
        forever #20 core_clk_in = ~core_clk_in;
    end

    // A done pulse wider than one cycle is counted twice and shows up.
    always @(posedge core_clk_in) begin
        if (write_done_flag_out === 1'b1) dones_seen++;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs

    task automatic finish_test();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test

    task automatic compare(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : compare

    task automatic reg_wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        sfr_addr_in  <= a;
        sfr_wdata_in <= d;
        sfr_wr_in    <= 1'b1;
        @(posedge core_clk_in);
        sfr_wr_in    <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [8:0] a, output logic [7:0] v);
        @(posedge core_clk_in);
        sfr_addr_in <= a;
        @(negedge core_clk_in);
        v = sfr_rdata_out;
    endtask : reg_rd

    task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
        logic [7:0] v;
        reg_rd(a, v);
        compare(v, exp);
    endtask : rd_chk

    // Software style polling, bounded so a stuck strobe cannot hang.
    task automatic poll(input int pos);
        logic [7:0] v;
        int         n;
        v = 8'hff;
        for (n = 0; n < 20 && v[pos] !== 1'b0; n++) reg_rd(CREG, v);
        compare({7'h00, v[pos]}, 8'h00);
    endtask : poll

    task automatic nvm_write(input logic [4:0] a, input logic [7:0] d,
                             input logic en);
        reg_wr(AREG, {3'h0, a});
        reg_wr(DREG, d);
        reg_wr(CREG, en ? 8'h08 : 8'h00);
        reg_wr(CREG, en ? 8'h0C : 8'h04);
        rd_chk(CREG, en ? 8'h0C : 8'h00);
        @(posedge core_clk_in);
        timer_tick_in <= 1'b1;
        if (en) poll(nvac_pkg::WR_POS);
        else repeat (6) @(posedge core_clk_in);
        @(posedge core_clk_in);
        timer_tick_in <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        if (en) begin
            rd_chk(CREG, 8'h08);
            mem[a] = d;
            dones_exp++;
        end
        reg_wr(CREG, 8'h00);
    endtask : nvm_write

    task automatic nvm_read(input logic [4:0] a);
        reg_wr(AREG, {3'h0, a});
        reg_wr(CREG, 8'h02);
        reg_wr(CREG, 8'h03);
        poll(nvac_pkg::RD_POS);
        reg_wr(AREG, {3'h0, ~a});
        rd_chk(DREG, mem[a]);
        rd_chk(CREG, 8'h02);
        reg_wr(CREG, 8'h00);
    endtask : nvm_read

    initial begin
        logic [4:0] a;
        rst_n_in      = 1'b0;
        sfr_addr_in   = 9'h0_00;
        sfr_wr_in     = 1'b0;
        sfr_wdata_in  = 8'h00;
        timer_tick_in = 1'b0;
        seed          = 32'h0000_20d9;
        repeat (20) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        rd_chk(AREG, 8'h00);
        rd_chk(DREG, 8'h00);
        rd_chk(CREG, 8'h00);
        rd_chk(9'h0_02, 8'h00);
        reg_wr(AREG, 8'hFF);
        rd_chk(AREG, 8'h1F);
        reg_wr(DREG, 8'hA5);
        rd_chk(DREG, 8'hA5);
        reg_wr(CREG, 8'hF0);
        rd_chk(CREG, 8'h00);
        reg_wr(CREG, 8'h0C);
        rd_chk(CREG, 8'h08);
        reg_wr(CREG, 8'h00);
        nvm_write(5'h00, 8'h3C, 1'b1);
        nvm_write(5'h1F, 8'hC3, 1'b1);
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            a    = seed[4:0];
            nvm_write(a, seed[15:8], 1'b1);
            nvm_read(a);
        end
        nvm_read(5'h00);
        nvm_read(5'h1F);
        nvm_write(5'h1F, 8'h3C, 1'b0);
        nvm_read(5'h1F);
        reg_wr(DREG, 8'h5A);
        reg_wr(CREG, 8'h01);
        rd_chk(CREG, 8'h00);
        rd_chk(DREG, 8'h5A);
        reg_wr(CREG, 8'h0A);
        reg_wr(CREG, 8'h0F);
        rd_chk(CREG, 8'h0A);
        rd_chk(DREG, 8'h5A);
        reg_wr(CREG, 8'h00);
        repeat (4) @(posedge core_clk_in);
        compare(8'(dones_seen), 8'(dones_exp));
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge core_clk_in);
        miscompares++;
        finish_test();
    end
endmodule : tb_top
